// File: hw/npc_bus_cycle.sv
// one command, address, write or read strobe cycle on the flash port
`timescale 1ns/1ps
`default_nettype none
`include "npc_regs.svh"
module npc_bus_cycle import npc_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // request
    input wire logic start,
    input wire npc_kind_e kind,
    input wire logic [7:0] value,
    // answer
    output logic done,
    output logic [7:0] rd_byte,
    // pins
    input wire logic [7:0] io_in_sync,
    output npc_pins_s pins
);
    typedef struct packed {
        npc_phase_e ph;
        npc_kind_e kind;
        logic [3:0] cnt;
        logic done;
        logic [7:0] rd;
        npc_pins_s pins;
    } npc_cyc_s;

    localparam npc_pins_s PINS_IDLE = '{1'b0, 1'b0, 1'b1, 1'b1, 8'h00, 1'b0};
    localparam npc_cyc_s CYC_RESET = '{NPC_PH_IDLE, NPC_K_CMD, 4'h0, 1'b0, 8'h00, PINS_IDLE};

    npc_cyc_s s;
    npc_cyc_s next_s;

    // ----------------------------------------
    // strobe sequencing
    // ----------------------------------------
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        case (s.ph)
            NPC_PH_IDLE: begin
                if (start) begin
                    next_s.ph = NPC_PH_SETUP;
                    next_s.kind = kind;
                    next_s.pins.cle = (kind == NPC_K_CMD);
                    next_s.pins.ale = (kind == NPC_K_ADDR);
                    next_s.pins.io_out = value;
                    next_s.pins.io_oe = (kind != NPC_K_RD);
                end
            end
            NPC_PH_SETUP: begin
                next_s.ph = NPC_PH_LOW;
                if (s.kind == NPC_K_RD) begin
                    // extra cycles cover the input synchroniser
                    next_s.cnt = 4'(`NPC_LOW_CYC + `NPC_SYNC_CYC - 1);
                    next_s.pins.read_strobe_n = 1'b0;
                end else begin
                    next_s.cnt = 4'(`NPC_LOW_CYC - 1);
                    next_s.pins.we_n = 1'b0;
                end
            end
            NPC_PH_LOW: begin
                if (s.cnt != 4'h0) begin
                    next_s.cnt = s.cnt - 4'h1;
                end else begin
                    next_s.ph = NPC_PH_HOLD;
                    next_s.cnt = 4'(`NPC_HOLD_CYC - 1);
                    next_s.pins.we_n = 1'b1;
                    next_s.pins.read_strobe_n = 1'b1;
                    if (s.kind == NPC_K_RD) begin
                        next_s.rd = io_in_sync;
                    end
                end
            end
            NPC_PH_HOLD: begin
                if (s.cnt != 4'h0) begin
                    next_s.cnt = s.cnt - 4'h1;
                end else begin
                    next_s.ph = NPC_PH_IDLE;
                    next_s.done = 1'b1;
                    next_s.pins = PINS_IDLE;
                end
            end
            default: begin
                next_s = CYC_RESET;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s <= CYC_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign done = s.done;
    assign rd_byte = s.rd;
    assign pins = s.pins;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_we_low_width: assert property ($fell(pins.we_n) |-> ##1 !pins.we_n ##1 pins.we_n)
        else $error("write strobe low time wrong");
    a_latch_io_driven: assert property (!pins.we_n |-> pins.io_oe && !(pins.cle && pins.ale))
        else $error("latch cycle without driven port");
    a_read_no_drive: assert property (!pins.read_strobe_n |-> !pins.io_oe && pins.we_n)
        else $error("port driven during read");
endmodule // npc_bus_cycle
`default_nettype wire

// File: hw/npc_ctrl.sv
// host controller that sequences a byte-wide flash through its strobe pins
// What this block does
// - erase: setup code then two address cycles
// - erase starts only on confirm after address
// - re-issue read command after status read; here sent only when NPC_OP_MAIN_READ is ordered, polls end in status mode
// - identification: code, zero address, two reads
// - write protect blocks writes; hold during power
// - program confirm only after data loading
`timescale 1ns/1ps
`default_nettype none
`include "npc_regs.svh"
module npc_ctrl import npc_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // user orders
    input wire logic req_valid,
    input wire npc_req_s req,
    output logic req_ready,
    input wire logic write_enable,
    output logic done,
    output logic failed,
    output logic [7:0] status,
    output logic [7:0] id_maker,
    output logic [7:0] id_device,
    // flash pins
    output logic ce_n,
    output logic cle,
    output logic ale,
    output logic we_n,
    output logic read_strobe_n,
    output logic write_protect_n,
    output logic [7:0] io_out,
    output logic io_oe,
    input wire logic [7:0] io_in,
    input wire logic busy_n_in
);
    typedef struct packed {
        npc_state_e st;
        npc_op_e op;
        logic [22:0] addr;
        logic [7:0] data;
        logic [2:0] idx;
        logic poll;
        logic [3:0] cnt;
        logic ce_n;
        logic wp_n;
        logic [7:0] status;
        logic [7:0] maker;
        logic [7:0] device;
        logic failed;
        logic done;
        logic [7:0] io_s1;
        logic [7:0] io_s2;
        logic bsy_s1;
        logic bsy_s2;
    } npc_ctl_s;

    localparam npc_ctl_s CTL_RESET = '{NPC_ST_IDLE, NPC_OP_RESET, 23'h000000, 8'h00, 3'h0, 1'b0, 4'h0,
        1'b1, 1'b0, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0};

    npc_ctl_s s;
    npc_ctl_s next_s;
    npc_op_e eff_op;
    npc_step_s step;
    logic cyc_start;
    logic cyc_done;
    logic [7:0] cyc_rd;
    npc_pins_s pins;

    // ----------------------------------------
    // per-operation strobe programme
    // ----------------------------------------
    function automatic npc_step_s step_of(npc_op_e op, logic [2:0] idx, logic [22:0] a, logic [7:0] d);
        npc_step_s r;
        r = '{NPC_K_CMD, 8'h00, 1'b1, 1'b0};
        case (op)
            NPC_OP_RESET: begin
                r = '{NPC_K_CMD, `NPC_CMD_RESET, 1'b1, 1'b1};
            end
            NPC_OP_STATUS: begin
                if (idx == 3'd0) r = '{NPC_K_CMD, `NPC_CMD_STATUS, 1'b0, 1'b0};
                else r = '{NPC_K_RD, 8'h00, 1'b1, 1'b0};
            end
            NPC_OP_ERASE: begin
                case (idx)
                    3'd0: r = '{NPC_K_CMD, `NPC_CMD_ERASE_SETUP, 1'b0, 1'b0};
                    3'd1: r = '{NPC_K_ADDR, {a[16:13], 4'h0}, 1'b0, 1'b0};
                    3'd2: r = '{NPC_K_ADDR, {2'b00, a[22:17]}, 1'b0, 1'b0};
                    default: r = '{NPC_K_CMD, `NPC_CMD_ERASE_CONFIRM, 1'b1, 1'b1};
                endcase
            end
            NPC_OP_PROGRAM: begin
                case (idx)
                    3'd0: r = '{NPC_K_CMD, `NPC_CMD_SERIAL_IN, 1'b0, 1'b0};
                    3'd1: r = '{NPC_K_ADDR, a[7:0], 1'b0, 1'b0};
                    3'd2: r = '{NPC_K_ADDR, a[16:9], 1'b0, 1'b0};
                    3'd3: r = '{NPC_K_ADDR, {2'b00, a[22:17]}, 1'b0, 1'b0};
                    3'd4: r = '{NPC_K_WR, d, 1'b0, 1'b0};
                    default: r = '{NPC_K_CMD, `NPC_CMD_PROG_CONFIRM, 1'b1, 1'b1};
                endcase
            end
            NPC_OP_ID: begin
                case (idx)
                    3'd0: r = '{NPC_K_CMD, `NPC_CMD_ID_READ, 1'b0, 1'b0};
                    3'd1: r = '{NPC_K_ADDR, `NPC_ID_ADDR, 1'b0, 1'b0};
                    3'd2: r = '{NPC_K_RD, 8'h00, 1'b0, 1'b0};
                    default: r = '{NPC_K_RD, 8'h00, 1'b1, 1'b0};
                endcase
            end
            NPC_OP_MAIN_READ: begin
                // leaves status mode before further page reading
                r = '{NPC_K_CMD, `NPC_CMD_MAIN_READ, 1'b1, 1'b0};
            end
            default: begin
                r = '{NPC_K_CMD, 8'h00, 1'b1, 1'b0};
            end
        endcase
        return r;
    endfunction

    assign eff_op = s.poll ? NPC_OP_STATUS : s.op;
    assign step = step_of(eff_op, s.idx, s.addr, s.data);
    assign cyc_start = (s.st == NPC_ST_STEP);

    // ----------------------------------------
    // operation sequencer
    // ----------------------------------------
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.io_s1 = io_in;
        next_s.io_s2 = s.io_s1;
        next_s.bsy_s1 = busy_n_in;
        next_s.bsy_s2 = s.bsy_s1;
        case (s.st)
            NPC_ST_IDLE: begin
                next_s.wp_n = write_enable;
                if (req_valid) begin
                    next_s.op = req.op;
                    next_s.addr = req.addr;
                    next_s.data = req.data;
                    next_s.idx = 3'h0;
                    next_s.poll = 1'b0;
                    next_s.failed = 1'b0;
                    next_s.ce_n = 1'b0;
                    next_s.st = NPC_ST_STEP;
                end
            end
            NPC_ST_STEP: begin
                next_s.st = NPC_ST_WAITC;
            end
            NPC_ST_WAITC: begin
                if (cyc_done) begin
                    if (step.kind == NPC_K_RD) begin
                        if (eff_op == NPC_OP_ID) begin
                            if (s.idx == 3'd2) next_s.maker = cyc_rd;
                            else next_s.device = cyc_rd;
                        end else begin
                            next_s.status = cyc_rd;
                        end
                    end
                    if (!step.last) begin
                        next_s.idx = s.idx + 3'h1;
                        next_s.st = NPC_ST_STEP;
                    end else if (step.busy) begin
                        next_s.cnt = 4'(`NPC_WB_CYC + `NPC_SYNC_CYC - 1);
                        next_s.st = NPC_ST_WAIT_WB;
                    end else if (s.poll && !cyc_rd[`NPC_SR_READY]) begin
                        // still busy: read status again without a new command
                        next_s.st = NPC_ST_STEP;
                    end else begin
                        next_s.st = NPC_ST_FINISH;
                    end
                end
            end
            NPC_ST_WAIT_WB: begin
                if (s.cnt != 4'h0) next_s.cnt = s.cnt - 4'h1;
                else next_s.st = NPC_ST_WAIT_RDY;
            end
            NPC_ST_WAIT_RDY: begin
                if (s.bsy_s2) begin
                    if (s.op == NPC_OP_ERASE || s.op == NPC_OP_PROGRAM) begin
                        next_s.poll = 1'b1;
                        next_s.idx = 3'h0;
                        next_s.st = NPC_ST_STEP;
                    end else begin
                        next_s.st = NPC_ST_FINISH;
                    end
                end
            end
            NPC_ST_FINISH: begin
                next_s.st = NPC_ST_IDLE;
                next_s.ce_n = 1'b1;
                next_s.done = 1'b1;
                if (s.poll) next_s.failed = s.status[`NPC_SR_PASS_FAIL] | ~s.status[`NPC_SR_UNPROT];
            end
            default: begin
                next_s = CTL_RESET;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s <= CTL_RESET;
        end else begin
            s <= next_s;
        end
    end

    npc_bus_cycle u_cycle (
        .clk(clk),
        .reset_n(reset_n),
        .start(cyc_start),
        .kind(step.kind),
        .value(step.value),
        .done(cyc_done),
        .rd_byte(cyc_rd),
        .io_in_sync(s.io_s2),
        .pins(pins)
    );

    assign req_ready = (s.st == NPC_ST_IDLE);
    assign done = s.done;
    assign failed = s.failed;
    assign status = s.status;
    assign id_maker = s.maker;
    assign id_device = s.device;
    assign ce_n = s.ce_n;
    assign write_protect_n = s.wp_n;
    assign cle = pins.cle;
    assign ale = pins.ale;
    assign we_n = pins.we_n;
    assign read_strobe_n = pins.read_strobe_n;
    assign io_out = pins.io_out;
    assign io_oe = pins.io_oe;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_erase_setup_first: assert property (cyc_start && eff_op == NPC_OP_ERASE && s.idx == 3'd0 |-> ##2 cle && step.value == `NPC_CMD_ERASE_SETUP)
        else $error("erase does not open with setup code");
    a_erase_confirm_late: assert property (cyc_start && step.value == `NPC_CMD_ERASE_CONFIRM && step.kind == NPC_K_CMD |-> eff_op == NPC_OP_ERASE && s.idx == 3'd3)
        else $error("erase confirm out of order");
    a_prog_after_data: assert property (cyc_start && step.value == `NPC_CMD_PROG_CONFIRM && step.kind == NPC_K_CMD |-> eff_op == NPC_OP_PROGRAM && s.idx == 3'd5)
        else $error("program confirm without data");
    a_id_addr_zero: assert property (ale && s.op == NPC_OP_ID |-> io_out == `NPC_ID_ADDR)
        else $error("identification address not zero");
    a_wp_follows_user: assert property ($rose(write_protect_n) |-> $past(write_enable) && $past(req_ready))
        else $error("write protect released without order");
    a_main_read_code: assert property (cyc_start && s.op == NPC_OP_MAIN_READ |-> ##2 cle && io_out == `NPC_CMD_MAIN_READ)
        else $error("read command code wrong");
    a_done_single: assert property (done |-> ce_n && req_ready ##1 !done)
        else $error("done not a single pulse");
    a_wait_busy: assert property (s.st == NPC_ST_WAIT_RDY && !s.bsy_s2 |=> s.st == NPC_ST_WAIT_RDY && we_n && read_strobe_n)
        else $error("strobe while device busy");

    c_erase_done: cover property (done && s.op == NPC_OP_ERASE);
    c_prog_done: cover property (done && s.op == NPC_OP_PROGRAM);
    c_id_done: cover property (done && s.op == NPC_OP_ID);
    c_poll_repeat: cover property (s.poll && cyc_done && !cyc_rd[`NPC_SR_READY]);
endmodule // npc_ctrl
`default_nettype wire

// File: hw/npc_pkg.sv
// types shared by the flash controller modules
package npc_pkg;
    typedef enum logic [2:0] {
        NPC_OP_RESET = 3'b000,
        NPC_OP_STATUS = 3'b001,
        NPC_OP_ERASE = 3'b010,
        NPC_OP_PROGRAM = 3'b011,
        NPC_OP_ID = 3'b100,
        NPC_OP_MAIN_READ = 3'b101
    } npc_op_e;

    typedef enum logic [1:0] {
        NPC_K_CMD = 2'b00,
        NPC_K_ADDR = 2'b01,
        NPC_K_WR = 2'b10,
        NPC_K_RD = 2'b11
    } npc_kind_e;

    typedef enum logic [1:0] {
        NPC_PH_IDLE = 2'b00,
        NPC_PH_SETUP = 2'b01,
        NPC_PH_LOW = 2'b10,
        NPC_PH_HOLD = 2'b11
    } npc_phase_e;

    typedef enum logic [2:0] {
        NPC_ST_IDLE = 3'b000,
        NPC_ST_STEP = 3'b001,
        NPC_ST_WAITC = 3'b010,
        NPC_ST_WAIT_WB = 3'b011,
        NPC_ST_WAIT_RDY = 3'b100,
        NPC_ST_FINISH = 3'b101
    } npc_state_e;

    typedef struct packed {
        npc_op_e op;
        logic [22:0] addr;
        logic [7:0] data;
    } npc_req_s;

    typedef struct packed {
        npc_kind_e kind;
        logic [7:0] value;
        logic last;
        logic busy;
    } npc_step_s;

    typedef struct packed {
        logic cle;
        logic ale;
        logic we_n;
        logic read_strobe_n;
        logic [7:0] io_out;
        logic io_oe;
    } npc_pins_s;
endpackage

// File: hw/npc_regs.svh
// command codes, status bit positions and timing counts of the flash controller
`ifndef NPC_REGS_SVH
`define NPC_REGS_SVH

// ----------------------------------------
// command codes
// ----------------------------------------
`define NPC_CMD_MAIN_READ 8'h00
`define NPC_CMD_STATUS 8'h70
`define NPC_CMD_ERASE_SETUP 8'h60
`define NPC_CMD_ERASE_CONFIRM 8'hd0
`define NPC_CMD_PROG_CONFIRM 8'h10
`define NPC_CMD_SERIAL_IN 8'h80
`define NPC_CMD_ID_READ 8'h90
`define NPC_CMD_RESET 8'hff
`define NPC_ID_ADDR 8'h00

// ----------------------------------------
// operation_status fields
// ----------------------------------------
`define NPC_SR_PASS_FAIL 0
`define NPC_SR_READY 6
`define NPC_SR_UNPROT 7

// ----------------------------------------
// timing
// ----------------------------------------
`define NPC_CLK_MHZ 25
`define NPC_T_STROBE_NS 50
`define NPC_T_HOLD_NS 40
`define NPC_T_WB_NS 100
`define NPC_CYC(ns) ((((ns) * `NPC_CLK_MHZ) + 999) / 1000)
`define NPC_LOW_CYC `NPC_CYC(`NPC_T_STROBE_NS)
`define NPC_HOLD_CYC `NPC_CYC(`NPC_T_HOLD_NS)
`define NPC_WB_CYC `NPC_CYC(`NPC_T_WB_NS)
`define NPC_SYNC_CYC 2

`endif

// File: testbench/nand_program_erase_status_control_tb_top.sv
// self-checking bench for the flash controller against a behavioural device
`timescale 1ns/1ps
`default_nettype none
module nand_program_erase_status_control_tb_top import npc_pkg::*;;
    localparam logic [7:0] MAKER = 8'h5a; // arbitrary value
    localparam logic [7:0] DEVICE = 8'h3c; // arbitrary value
    localparam logic [22:0] A1 = 23'h012245;
    localparam logic [22:0] A2 = 23'h014000;
    logic clk, reset_n, req_valid, req_ready, write_enable, done, failed;
    npc_req_s req;
    logic [7:0] status, id_maker, id_device, io_out, dev_out, io_last;
    logic ce_n, cle, ale, we_n, read_strobe_n, write_protect_n, io_oe, dev_oe, busy_pull, slow, fail_next;
    wire logic [7:0] io_wire;
    wire logic busy_n_wire;
    int miscompares = 0;
    int check_count = 0;

    // released port shows the inverse of its last level; busy wire pulled up
    assign io_wire = io_oe ? io_out : (dev_oe ? dev_out : ~io_last);
    assign busy_n_wire = busy_pull ? 1'b0 : 1'b1;
    always @(io_wire) if (io_oe || dev_oe) io_last = io_wire;
    always #20 clk = ~clk;

    npc_ctrl i_dut (.clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .write_enable(write_enable), .done(done), .failed(failed), .status(status), .id_maker(id_maker),
        .id_device(id_device), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .read_strobe_n(read_strobe_n),
        .write_protect_n(write_protect_n), .io_out(io_out), .io_oe(io_oe), .io_in(io_wire),
        .busy_n_in(busy_n_wire));
    npc_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) i_flash (.ce_n(ce_n), .cle(cle), .ale(ale),
        .we_n(we_n), .read_strobe_n(read_strobe_n), .write_protect_n(write_protect_n), .io(io_wire),
        .dev_out(dev_out), .dev_oe(dev_oe), .busy_pull(busy_pull), .slow(slow), .fail_next(fail_next));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic order(input npc_op_e op, input logic [22:0] a, input logic [7:0] d);
        int n;
        @(negedge clk);
        req_valid = 1'b1;
        req.op = op;
        req.addr = a;
        req.data = d;
        @(negedge clk);
        req_valid = 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 3000);
        chk({7'h00, done}, 8'h01, "done");
        // later stimulus changes land on a falling edge
        @(negedge clk);
    endtask

    task automatic conclude();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        #2000000;
        miscompares++;
        conclude();
    end

    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        write_enable = 1'b0;
        slow = 1'b0;
        fail_next = 1'b0;
        io_last = 8'h00;
        repeat (10) @(negedge clk);
        chk({ce_n, write_protect_n, io_oe, req_ready}, 8'h09, "reset pins");
        reset_n = 1'b1;
        $display("test reset ended");
        order(NPC_OP_STATUS, '0, '0);
        chk(status, 8'h40, "protected status");
        write_enable = 1'b1;
        order(NPC_OP_STATUS, '0, '0);
        chk(status, 8'hc0, "open status");
        $display("test status ended");
        order(NPC_OP_ID, '0, '0);
        chk(id_maker, MAKER, "maker");
        chk(id_device, DEVICE, "device");
        $display("test id ended");
        for (int i = 0; i < 2; i++) begin
            slow = i[0];
            order(NPC_OP_PROGRAM, i ? A2 : A1, i ? 8'h3c : 8'ha5);
            chk({status[7:6], 5'h00, failed}, 8'hc0, "program ok");
        end
        slow = 1'b0;
        chk(i_flash.peek(A1), 8'ha5, "programmed");
        order(NPC_OP_PROGRAM, A1, 8'hff);
        chk({7'h00, failed}, 8'h00, "no false fail");
        chk(i_flash.peek(A1), 8'ha5, "cells kept");
        fail_next = 1'b1;
        order(NPC_OP_PROGRAM, 23'h000100, 8'h00);
        chk({status, 7'h00, failed}, 16'hc101, "program fail");
        fail_next = 1'b0;
        $display("test program ended");
        write_enable = 1'b0;
        order(NPC_OP_PROGRAM, 23'h000200, 8'h00);
        chk({status[7], 6'h00, failed}, 8'h01, "protected program");
        chk(i_flash.peek(23'h000200), 8'hff, "protected cells");
        write_enable = 1'b1;
        $display("test protect ended");
        order(NPC_OP_ERASE, 23'h013e00, '0);
        chk({status, 7'h00, failed}, 16'hc000, "erase ok");
        chk(i_flash.peek(A1), 8'hff, "block erased");
        chk(i_flash.peek(A2), 8'h3c, "next block kept");
        fail_next = 1'b1;
        order(NPC_OP_ERASE, A2, '0);
        chk({status, 7'h00, failed}, 16'hc101, "erase fail");
        fail_next = 1'b0;
        $display("test erase ended");
        order(NPC_OP_RESET, '0, '0);
        order(NPC_OP_MAIN_READ, '0, '0);
        chk({ce_n, req_ready}, 8'h03, "idle after read");
        $display("test reset and read ended");
        conclude();
    end
endmodule // nand_program_erase_status_control_tb_top
`default_nettype wire

// File: testbench/npc_flash_model.sv
// behavioural byte-wide flash device answering the controller's strobes
`timescale 1ns/1ps
`default_nettype none
module npc_flash_model #(
    parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'h3c, // arbitrary value
    parameter int FAST_NS = 400,
    parameter int SLOW_NS = 20000
) (
    // strobes from the host
    input wire logic ce_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic read_strobe_n,
    input wire logic write_protect_n,
    // shared port
    input wire logic [7:0] io,
    output logic [7:0] dev_out,
    output logic dev_oe,
    // ready/busy pull-down, high while pulling the wire low
    output logic busy_pull,
    // test controls
    input wire logic slow,
    input wire logic fail_next
);
    typedef enum logic [1:0] {NPC_M_READ, NPC_M_IDLE, NPC_M_STATUS, NPC_M_ID} npc_mode_e;
    logic [7:0] mem [int];
    npc_mode_e mode = NPC_M_READ;
    logic busy = 1'b0;
    logic fail = 1'b0;
    logic loaded = 1'b0;
    logic [7:0] last_cmd = 8'h00;
    logic [7:0] wdata = 8'hff;
    logic [7:0] adr [3];
    logic [7:0] status_byte;
    int n_adr = 0;
    int n_rd = 0;
    int gen = 0;
    // supply detector of the device, held good in this bench
    logic supply_ok = 1'b1;

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign status_byte = {write_protect_n, ~busy, 5'h00, fail};
    assign dev_oe = !ce_n && !read_strobe_n && (mode == NPC_M_STATUS || mode == NPC_M_ID);
    assign dev_out = (mode == NPC_M_STATUS) ? status_byte : (n_rd == 0 ? MAKER_CODE : DEVICE_CODE);
    assign busy_pull = busy;

    function automatic logic [7:0] peek(input logic [22:0] a);
        return mem.exists(a) ? mem[a] : 8'hff;
    endfunction

    // ----------------------------------------
    // internal program and erase
    // ----------------------------------------
    task automatic run(input logic prog);
        logic [22:0] a;
        logic [7:0] old;
        logic [7:0] tgt;
        int q[$];
        if (!write_protect_n) return;
        busy = 1'b1;
        gen++;
        if (prog) begin
            a = {adr[2][5:0], adr[1], 1'b0, adr[0]};
            old = peek(a);
            tgt = old & wdata;
            mem[a] = fail_next ? (tgt | (old & 8'h01)) : tgt;
            fail = (mem[a] !== tgt);
        end else begin
            fail = fail_next;
            if (!fail_next) begin
                foreach (mem[k]) if (k[22:13] == {adr[1][5:0], adr[0][7:4]}) q.push_back(k);
                foreach (q[i]) mem.delete(q[i]);
            end
        end
        fork
            begin
                int g = gen;
                #(slow ? SLOW_NS : FAST_NS);
                if (g == gen) busy = 1'b0;
            end
        join_none
    endtask

    task automatic command(input logic [7:0] c);
        if (busy && c != 8'h70 && c != 8'hff) return;
        case (c)
            8'h70: mode = NPC_M_STATUS;
            8'hff: begin
                gen++;
                busy = 1'b0;
                mode = NPC_M_IDLE;
            end
            8'h90: begin
                mode = NPC_M_ID;
                n_rd = 0;
            end
            8'h10: if (last_cmd == 8'h80 && loaded) run(1'b1);
            8'hd0: if (last_cmd == 8'h60 && n_adr == 2) run(1'b0);
            default: begin
                n_adr = 0;
                loaded = 1'b0;
                if (c == 8'h00) mode = NPC_M_READ;
            end
        endcase
        last_cmd = c;
    endtask

    // ----------------------------------------
    // strobe edges
    // ----------------------------------------
    always @(posedge we_n) begin
        if (!supply_ok) n_adr = 0;
        else if (!ce_n && cle) command(io);
        else if (!ce_n && !busy && ale) begin
            if (n_adr < 3) adr[n_adr] = io;
            n_adr++;
        end else if (!ce_n && !busy) begin
            wdata = io;
            loaded = 1'b1;
        end
    end

    always @(posedge read_strobe_n) begin
        if (!ce_n && mode == NPC_M_ID) n_rd++;
    end
endmodule // npc_flash_model
`default_nettype wire
